/* File: rtl/move_and_multiply_instr_exec.sv */
// Decode and execute for file move, bank load, literal load, store and literal multiply
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RQ1] Two-word file move: source read first cycle, destination written second Q4, or third Q4 with extra_cycle.
// [RQ2] First word opcode 1100 holds source; second word prefix 1111 holds destination.
// [RQ3] Software never targets program counter low or stack top bytes with the move.
// [RQ4] Bank load writes literal low nibble into bank select, one cycle, no flags.
// [RQ5] Bank select upper four bits always read zero after a bank load.
// [RQ6] Literal load writes literal into accumulator in one cycle, no flags.
// [RQ7] Store decoded by upper bits 0110111, bit 8 bank selector, low byte address.
// [RQ8] Store copies accumulator to addressed file register in one cycle, no flags.
// [RQ9] Selector 0 picks quick bank; selector 1 uses bank select register.
// [RQ10] Extended mode, selector 0, address up to 5Fh becomes indexed literal offset.
// [RQ11] Literal multiply computes unsigned 8x8 accumulator times literal in one cycle.
// [RQ12] Product high and low bytes go to product registers; accumulator unchanged.
// [RQ13] Multiply leaves all status flags alone; zero product not signalled.
module move_and_multiply_instr_exec #(
  parameter int addr_width = 12
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Instruction fetch
  input  wire logic [15:0]           instr,
  input  wire logic                  instr_valid,
  input  wire logic                  extended_en,
  input  wire logic                  extra_cycle,
  // Data memory read
  output logic      [addr_width-1:0] rd_addr,
  output logic                       rd_en,
  input  wire logic [7:0]            rd_data,
  // Data memory write
  output logic      [addr_width-1:0] wr_addr,
  output logic      [7:0]            wr_data,
  output logic                       wr_en,
  output logic                       wr_indexed,
  // Architectural state
  output logic      [7:0]            acc,
  output logic      [7:0]            bank_select_register,
  output logic      [7:0]            product_high_byte,
  output logic      [7:0]            product_low_byte,
  output logic                       flags_we,
  output logic                       instr_done
);
  phase_if ph ();

  phase_gen u_phase (
    .clk  (clk),
    .rstn (rstn),
    .ph   (ph)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  instr_exec_pkg::exec_state_t state;
  instr_exec_pkg::exec_state_t next_state;
  logic [7:0]            move_data;
  logic [7:0]            next_move_data;
  logic [addr_width-1:0] next_rd_addr;
  logic                  next_rd_en;
  logic [addr_width-1:0] next_wr_addr;
  logic [7:0]            next_wr_data;
  logic                  next_wr_en;
  logic                  next_wr_indexed;
  logic [7:0]            next_acc;
  logic [7:0]            next_bank;
  logic [7:0]            next_prod_hi;
  logic [7:0]            next_prod_lo;
  logic                  next_done;
  logic [15:0]           product;
  logic                  sel_bit;
  logic [7:0]            faddr;
  logic                  read_slot;
  logic                  is_move_first;
  logic                  is_move_second;
  logic                  is_bank_load;
  logic                  is_lit_load;
  logic                  is_lit_mul;
  logic                  is_store;
  logic                  indexed_hit;

  assign sel_bit = instr[instr_exec_pkg::bank_sel_bit];
  assign faddr   = instr[7:0];
  // [RQ11] Unsigned multiply
  assign product = 16'(acc) * 16'(instr[7:0]);

  ////////////////////////////////////////////////////////////////////////////
  // Opcode decode; the move source is read in Q2, ahead of the Q4 decision,
  // so a first move word that arrives after Q2 would capture stale read data
  assign read_slot      = (ph.phase == 2'h1);
  assign is_move_first  = (instr[15:12] == instr_exec_pkg::op_move_first);
  assign is_move_second = (instr[15:12] == instr_exec_pkg::op_move_second);
  assign is_bank_load   = (instr[15:8] == instr_exec_pkg::op_bank_load);
  assign is_lit_load    = (instr[15:8] == instr_exec_pkg::op_lit_load);
  assign is_lit_mul     = (instr[15:8] == instr_exec_pkg::op_lit_mul);
  assign is_store       = (instr[15:9] == instr_exec_pkg::op_store);
  // [RQ10] Low file addresses become offsets only in extended mode
  assign indexed_hit    = !sel_bit && extended_en && (faddr <= instr_exec_pkg::indexed_limit);

  ////////////////////////////////////////////////////////////////////////////
  // Decode and execute; effects land in Q4 of the cycle
  always_comb begin
    next_state      = state;
    next_move_data  = move_data;
    next_rd_addr    = rd_addr;
    next_rd_en      = 1'b0;
    next_wr_addr    = wr_addr;
    next_wr_data    = wr_data;
    next_wr_en      = 1'b0;
    next_wr_indexed = 1'b0;
    next_acc        = acc;
    next_bank       = bank_select_register;
    next_prod_hi    = product_high_byte;
    next_prod_lo    = product_low_byte;
    next_done       = 1'b0;
    unique case (state)
      instr_exec_pkg::st_fetch: begin
        if (instr_valid && read_slot) begin
          // [RQ1] Source read in Q2 of first cycle
          if (is_move_first) begin
            next_rd_addr = instr[addr_width-1:0];
            next_rd_en   = 1'b1;
          end
        end
        if (instr_valid && ph.q4) begin
          // [RQ2] Two-word move, first word
          if (is_move_first) begin
            next_move_data = rd_data;
            next_state     = instr_exec_pkg::st_move_dest;
          // [RQ4] Bank nibble load
          end else if (is_bank_load) begin
            // [RQ5] Upper nibble forced to zero
            next_bank = {4'h0, instr[3:0]};
            next_done = 1'b1;
          // [RQ6] Literal to accumulator
          end else if (is_lit_load) begin
            next_acc  = instr[7:0];
            next_done = 1'b1;
          // [RQ12] Product split, accumulator kept
          end else if (is_lit_mul) begin
            next_prod_hi = product[15:8];
            next_prod_lo = product[7:0];
            next_done    = 1'b1;
          // [RQ7] Store decode
          end else if (is_store) begin
            // [RQ8] Accumulator to file
            next_wr_data = acc;
            next_wr_en   = 1'b1;
            next_done    = 1'b1;
            // [RQ10] Indexed literal offset
            if (indexed_hit) begin
              next_wr_indexed = 1'b1;
              next_wr_addr    = addr_width'(faddr);
            // [RQ9] Quick bank or banked access
            end else if (!sel_bit) begin
              next_wr_addr = addr_width'({4'h0, faddr});
            end else begin
              next_wr_addr = addr_width'({bank_select_register[3:0], faddr});
            end
          end
        end
      end
      instr_exec_pkg::st_move_dest: begin
        // [RQ2] Second word, prefix checked
        if (instr_valid && ph.q4 && is_move_second) begin
          // [RQ1] Destination write, optional stall
          if (extra_cycle) begin
            next_wr_addr = instr[addr_width-1:0];
            next_state   = instr_exec_pkg::st_move_stall;
          end else begin
            next_wr_addr = instr[addr_width-1:0];
            next_wr_data = move_data;
            next_wr_en   = 1'b1;
            next_done    = 1'b1;
            next_state   = instr_exec_pkg::st_fetch;
          end
        end
      end
      instr_exec_pkg::st_move_stall: begin
        // [RQ1] Third cycle when stalled
        if (ph.q4) begin
          next_wr_data = move_data;
          next_wr_en   = 1'b1;
          next_done    = 1'b1;
          next_state   = instr_exec_pkg::st_fetch;
        end
      end
      default: next_state = instr_exec_pkg::st_fetch;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state                <= instr_exec_pkg::st_fetch;
      move_data            <= 8'h00;
      rd_addr              <= '0;
      rd_en                <= 1'b0;
      wr_addr              <= '0;
      wr_data              <= 8'h00;
      wr_en                <= 1'b0;
      wr_indexed           <= 1'b0;
      acc                  <= instr_exec_pkg::acc_reset;
      bank_select_register <= instr_exec_pkg::bank_reset;
      product_high_byte    <= instr_exec_pkg::prod_reset;
      product_low_byte     <= instr_exec_pkg::prod_reset;
      flags_we             <= 1'b0;
      instr_done           <= 1'b0;
    end else begin
      state                <= next_state;
      move_data            <= next_move_data;
      rd_addr              <= next_rd_addr;
      rd_en                <= next_rd_en;
      wr_addr              <= next_wr_addr;
      wr_data              <= next_wr_data;
      wr_en                <= next_wr_en;
      wr_indexed           <= next_wr_indexed;
      acc                  <= next_acc;
      bank_select_register <= next_bank;
      product_high_byte    <= next_prod_hi;
      product_low_byte     <= next_prod_lo;
      // [RQ13] None of these instructions touch flags
      flags_we             <= 1'b0;
      instr_done           <= next_done;
    end
  end
endmodule // move_and_multiply_instr_exec
`default_nettype wire

/* File: rtl/instr_exec_pkg.sv */
// Constants and types shared by the move and multiply instruction executor
`default_nettype none
package instr_exec_pkg;
  // Opcode fields, compared against the upper bits of an instruction word
  localparam logic [3:0] op_move_first  = 4'hc;
  localparam logic [3:0] op_move_second = 4'hf;
  localparam logic [7:0] op_bank_load   = 8'h01;
  localparam logic [7:0] op_lit_load    = 8'h0e;
  localparam logic [7:0] op_lit_mul     = 8'h0d;
  localparam logic [6:0] op_store       = 7'h37;
  // Field positions
  localparam int bank_sel_bit = 8;
  // Indexed literal offset limit
  localparam logic [7:0] indexed_limit = 8'h5f;
  // Reset values
  localparam logic [7:0] acc_reset  = 8'h00;
  localparam logic [7:0] bank_reset = 8'h00;
  localparam logic [7:0] prod_reset = 8'h00;
  // Four-phase instruction cycle
  localparam logic [1:0] phase_q1 = 2'h0;
  localparam logic [1:0] phase_q4 = 2'h3;

  typedef enum logic [1:0] {
    st_fetch,
    st_move_dest,
    st_move_stall
  } exec_state_t;
endpackage

`default_nettype wire

/* File: rtl/phase_if.sv */
// Interface carrying the four-phase instruction clock enables
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
  logic       q1;
  logic       q4;
  logic [1:0] phase;
  modport gen (output q1, output q4, output phase);
  modport use_ (input q1, input q4, input phase);
endinterface
`default_nettype wire

/* File: rtl/phase_gen.sv */
// Four-phase instruction cycle generator
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Phase outputs
  phase_if.gen      ph
);
  logic [1:0] cnt;
  logic [1:0] next_cnt;

  always_comb begin
    next_cnt = cnt + 2'h1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= instr_exec_pkg::phase_q1;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign ph.phase = cnt;
  assign ph.q1    = (cnt == instr_exec_pkg::phase_q1);
  assign ph.q4    = (cnt == instr_exec_pkg::phase_q4);
endmodule // phase_gen
`default_nettype wire

/* File: sim/move_and_multiply_instr_exec_props.sv */
// Port-level checker for the move and multiply instruction executor
`timescale 1ns/1ps
`default_nettype none
module move_and_multiply_instr_exec_props #(
  parameter int addr_width = 12
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // Inputs seen
  input wire logic [15:0]           instr,
  input wire logic                  extended_en,
  // Outputs watched
  input wire logic                  rd_en,
  input wire logic [addr_width-1:0] wr_addr,
  input wire logic [7:0]            wr_data,
  input wire logic                  wr_en,
  input wire logic                  wr_indexed,
  input wire logic [7:0]            acc,
  input wire logic [7:0]            bank_select_register,
  input wire logic [7:0]            product_high_byte,
  input wire logic [7:0]            product_low_byte,
  input wire logic                  flags_we,
  input wire logic                  instr_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic st;
  logic low;
  assign st  = instr[15:9] == instr_exec_pkg::op_store;
  assign low = !instr[8] && extended_en && instr[7:0] <= instr_exec_pkg::indexed_limit;
  ////////////////////////////////////////////////////////////////////////////
  // Move: one read, then the write a bounded span later
  sequence move_read;
    rd_en;
  endsequence
  sequence move_write;
    ##[4:16] wr_en;
  endsequence
  chk_move_write: assert property (move_read |-> move_write)
    else $error("move write did not follow the read");
  chk_read_pulse: assert property (rd_en |=> !rd_en)
    else $error("move read strobe longer than one clock");
  chk_done_pulse: assert property (instr_done |=> !instr_done)
    else $error("done strobe longer than one clock");
  chk_flags_quiet: assert property (!flags_we)
    else $error("status flags written");
  chk_bank_upper: assert property (bank_select_register[7:4] == 4'h0)
    else $error("bank select upper nibble not zero");
  chk_bank_load: assert property (
    instr_done && instr[15:8] == instr_exec_pkg::op_bank_load
    |-> bank_select_register == {4'h0, instr[3:0]})
    else $error("bank load value wrong");
  chk_lit_load: assert property (
    instr_done && instr[15:8] == instr_exec_pkg::op_lit_load
    |-> acc == instr[7:0])
    else $error("literal load value wrong");
  chk_mul_product: assert property (
    instr_done && instr[15:8] == instr_exec_pkg::op_lit_mul
    |-> {product_high_byte, product_low_byte} == 16'(acc) * 16'(instr[7:0]) && $stable(acc))
    else $error("product wrong or accumulator changed");
  chk_store_data: assert property (wr_en && st |-> wr_data == acc)
    else $error("store data not the accumulator");
  chk_store_quick: assert property (
    wr_en && st && !instr[8] && !low
    |-> wr_addr == {4'h0, instr[7:0]} && !wr_indexed)
    else $error("quick bank address wrong");
  chk_store_banked: assert property (
    wr_en && st && instr[8]
    |-> wr_addr == {bank_select_register[3:0], instr[7:0]})
    else $error("banked address wrong");
  chk_store_indexed: assert property (
    wr_en && st && low
    |-> wr_indexed && wr_addr == {4'h0, instr[7:0]})
    else $error("indexed store wrong");
endmodule // move_and_multiply_instr_exec_props

bind move_and_multiply_instr_exec move_and_multiply_instr_exec_props #(
  .addr_width(addr_width)
) props (.clk(clk), .rstn(rstn), .instr(instr), .extended_en(extended_en), .rd_en(rd_en),
  .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en), .wr_indexed(wr_indexed), .acc(acc),
  .bank_select_register(bank_select_register), .product_high_byte(product_high_byte),
  .product_low_byte(product_low_byte), .flags_we(flags_we), .instr_done(instr_done));
`default_nettype wire

/* File: sim/move_and_multiply_instr_exec_test.sv */
// Self-checking testbench for the move and multiply instruction executor
`timescale 1ns/1ps
`default_nettype none
module move_and_multiply_instr_exec_test;
  logic        clk, rstn, instr_valid, extended_en, extra_cycle, rd_en, wr_en, wr_indexed;
  logic        flags_we, instr_done, wi;
  logic [15:0] instr;
  logic [11:0] rd_addr, wr_addr, wa;
  logic [7:0]  rd_data, wr_data, acc, bank_select_register, product_high_byte;
  logic [7:0]  product_low_byte, wd;
  int          fails, checked, n, n0;
  move_and_multiply_instr_exec DUT (.clk(clk), .rstn(rstn), .instr(instr),
    .instr_valid(instr_valid), .extended_en(extended_en), .extra_cycle(extra_cycle),
    .rd_addr(rd_addr), .rd_en(rd_en), .rd_data(rd_data), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_en(wr_en), .wr_indexed(wr_indexed), .acc(acc),
    .bank_select_register(bank_select_register), .product_high_byte(product_high_byte),
    .product_low_byte(product_low_byte), .flags_we(flags_we), .instr_done(instr_done));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Entered at a falling edge; holds the word until done, keeping any write seen
  task automatic run(input logic [15:0] w);
    instr = w;
    instr_valid = 1'b1;
    wa = 12'h000;
    wd = 8'h00;
    wi = 1'b0;
    for (n = 0; n < 20 && instr_done !== 1'b1; n++) begin
      @(negedge clk);
      if (wr_en === 1'b1) begin
        wa = wr_addr;
        wd = wr_data;
        wi = wr_indexed;
      end
    end
    if (n == 20) fails++;
    instr_valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_lit();
    logic [7:0]  a[3] = '{8'he2, 8'hff, 8'h00};
    logic [7:0]  k[3] = '{8'hc4, 8'hff, 8'h7f};
    logic [15:0] p[3] = '{16'had08, 16'hfe01, 16'h0000};
    for (int i = 0; i < 3; i++) begin
      run({8'h0e, a[i]});
      check({8'h00, acc}, {8'h00, a[i]});
      run({8'h0d, k[i]});
      check({product_high_byte, product_low_byte}, p[i]);
      check({8'h00, acc}, {8'h00, a[i]});
      check({15'h0000, flags_we}, 16'h0000);
    end
  endtask
  task automatic t_bank();
    run(16'h010a);
    check({8'h00, bank_select_register}, 16'h000a);
    run(16'h01a5);
    check({8'h00, bank_select_register}, 16'h0005);
  endtask
  task automatic t_store();
    logic [15:0] w[4] = '{16'h6e60, 16'h6e5f, 16'h6f33, 16'h6e10};
    logic        e[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
    logic [11:0] ad[4] = '{12'h060, 12'h05f, 12'h533, 12'h010};
    logic        x[4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    run(16'h0e4f);
    for (int i = 0; i < 4; i++) begin
      extended_en = e[i];
      run(w[i]);
      check({4'h0, wa}, {4'h0, ad[i]});
      check({8'h00, wd}, 16'h004f);
      check({15'h0000, wi}, {15'h0000, x[i]});
    end
    extended_en = 1'b0;
  endtask
  // Word one is held past the read; the second word is then driven with its 1111 prefix
  task automatic t_move(input logic ex);
    int k;
    extra_cycle = ex;
    rd_data = 8'h33;
    instr = 16'hcfff;
    instr_valid = 1'b1;
    for (k = 0; k < 20 && rd_en !== 1'b1; k++) @(negedge clk);
    check({4'h0, rd_addr}, 16'h0fff);
    repeat (4) @(negedge clk);
    // Destination kept clear of program counter and stack bytes
    run(16'hf0a5);
    check({4'h0, wa}, 16'h00a5);
    check({8'h00, wd}, 16'h0033);
    extra_cycle = 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    instr = 16'h0000;
    instr_valid = 1'b0;
    extended_en = 1'b0;
    extra_cycle = 1'b0;
    rd_data = 8'h00;
    fails = 0;
    checked = 0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_lit();
    t_bank();
    t_store();
    t_move(1'b0);
    n0 = n;
    t_move(1'b1);
    check(16'(n - n0), 16'h0004);
    close_out();
  end
  initial begin
    #20000;
    fails++;
    close_out();
  end
endmodule // move_and_multiply_instr_exec_test
`default_nettype wire
